/* File: common/capture_regs_pkg.sv */
package capture_regs_pkg;

  // register offsets
  localparam logic [7:0] ADDR_REVISION = 8'h00;
  localparam logic [7:0] ADDR_DIV_UPPER = 8'h01;
  localparam logic [7:0] ADDR_DIV_LOWER = 8'h02;
  localparam logic [7:0] ADDR_SYNC_DETECT = 8'h14;
  localparam logic [7:0] ADDR_OUT_FORMAT = 8'h15;
  localparam logic [7:0] ADDR_TEST_A = 8'h16;
  localparam logic [7:0] ADDR_TEST_B = 8'h17;
  localparam logic [7:0] ADDR_TEST_C = 8'h18;
  localparam logic [7:0] ADDR_TARGET_RED = 8'h19;
  localparam logic [7:0] ADDR_TARGET_GREEN = 8'h1A;
  localparam logic [7:0] ADDR_TARGET_BLUE = 8'h1B;
  localparam logic [7:0] ADDR_RESERVED_FIXED = 8'h1C;
  localparam logic [7:0] ADDR_AUTO_OFFSET = 8'h1D;
  localparam logic [7:0] ADDR_TEST_D = 8'h1E;

  // reset values
  localparam logic [7:0] RST_DIV_UPPER = 8'h69;
  localparam logic [7:0] RST_DIV_LOWER = 8'hD0;
  localparam logic [11:0] RST_DIV_VALUE = 12'h69D;
  localparam logic [7:0] RST_OUT_FORMAT = 8'hFF;
  localparam logic [7:0] RST_TEST_A = 8'h00;
  localparam logic [7:0] RST_TEST_B = 8'h00;
  localparam logic [7:0] RST_TEST_C = 8'h04;
  localparam logic [7:0] RST_TARGET = 8'h04;
  localparam logic [7:0] RST_RESERVED_FIXED = 8'h11;
  localparam logic [7:0] RST_AUTO_OFFSET = 8'h26;
  localparam logic [7:0] RST_TEST_D = 8'h00;

  // field positions
  localparam int FMT_FULL_444_BIT = 1;
  localparam int COAST_POL_BIT = 0;
  localparam int DIV_LSB_HI = 7;
  localparam int DIV_LSB_LO = 4;

  // divider value limits (divide ratio 2 .. 4095)
  localparam logic [11:0] DIV_VALUE_MIN = 12'h001;
  localparam logic [11:0] DIV_VALUE_MAX = 12'hFFE;

  // serial bus framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef struct packed {
    logic enable;
    logic hold;
    logic [3:0] fixed;
    logic [1:0] update_mode;
  } auto_offset_s;

  typedef struct packed {
    logic [5:0] fixed;
    logic full_444;
    logic fixed_low;
  } out_format_s;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b000,
    BUS_ADDR = 3'b001,
    BUS_ADDR_ACK = 3'b010,
    BUS_SUB = 3'b011,
    BUS_SUB_ACK = 3'b100,
    BUS_WRITE = 3'b101,
    BUS_WRITE_ACK = 3'b110,
    BUS_READ = 3'b111
  } bus_state_e;

endpackage

/* File: src/capture_ctrl_register_bank.sv */
// How it works
// (R1) sync detect register bit 0 reports the detected coast input polarity.
// (R2) host writes 111111 into output format bits 7:2.
// (R3) output format bit 1 picks 4:2:2 (0) or full 4:4:4 (1) output.
// (R4) host programs output format bit 0 to zero despite its default.
// (R5) three per-channel offset target registers, read/write, default 04.
// (R6) host writes 11h into the fixed reserved register.
// (R7) auto offset control bit 7 enables auto offset, default off.
// (R8) auto offset control bit 6 freezes the offset result, default off.
// (R9) host writes 1001 into auto offset control bits 5:2.
// (R10) auto offset control bits 1:0 pick update rate, default 10.
// (R11) host leaves the last test register at its default contents.
// (R12) read-only revision byte at offset 00.
// (R13) 12-bit divider value, upper byte from register 01; ratio is value plus one.
// (R14) divider values giving ratios 2 to 4095 are accepted.
// (R15) divider value resets to 1693: upper 69h, lower nibble D.
// (R16) divider takes effect only when the low-part register is written.
// (R17) larger divider value means faster pixel clock at a fixed line rate.
// (R18) test registers: 16h read/write, 17h and 18h read-only, 18h reads 04.
// (R19) divider value low four bits come from bits 7-4 of register 02.
`timescale 1ns/1ps
`default_nettype none

module capture_ctrl_register_bank
  import capture_regs_pkg::*;
#(
  parameter logic [6:0] DEVICE_ADDR = 7'h4C,  // arbitrary value
  parameter logic [7:0] REVISION = 8'h5A      // arbitrary value
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // serial control pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // detection inputs
  input wire logic coast_pol_in,
  // configuration outputs
  output logic [11:0] line_divider_value,
  output logic [12:0] divide_ratio,
  output out_format_s out_format,
  output auto_offset_s auto_offset,
  output logic [7:0] target_red,
  output logic [7:0] target_green,
  output logic [7:0] target_blue
);

  logic scl_meta_reg, scl_reg, scl_prev_reg;
  logic sda_meta_reg, sda_reg, sda_prev_reg;
  logic coast_meta_reg, coast_reg;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  bus_state_e state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg, tx_reg, pointer_reg, rd_byte;
  logic rw_reg, drive_reg, wr_pulse_reg;
  logic [7:0] wr_addr_reg, wr_data_reg;
  logic [7:0] div_upper_reg, div_lower_reg;
  logic [11:0] div_active_reg;
  logic [7:0] format_reg, test_a_reg, fixed_reg, auto_reg, test_d_reg;
  logic [7:0] target_reg [0:2];

  function automatic logic [11:0] clamp_div(input logic [11:0] v);
    if (v < DIV_VALUE_MIN) begin
      return DIV_VALUE_MIN;
    end else if (v > DIV_VALUE_MAX) begin
      return DIV_VALUE_MAX;
    end
    return v;
  endfunction

  function automatic logic [7:0] read_value(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      ADDR_REVISION: v = REVISION;  // see (R12)
      ADDR_DIV_UPPER: v = div_upper_reg;
      ADDR_DIV_LOWER: v = div_lower_reg;
      ADDR_SYNC_DETECT: v[COAST_POL_BIT] = coast_reg;  // see (R1)
      ADDR_OUT_FORMAT: v = format_reg;
      ADDR_TEST_A: v = test_a_reg;
      ADDR_TEST_B: v = RST_TEST_B;
      ADDR_TEST_C: v = RST_TEST_C;  // see (R18)
      ADDR_TARGET_RED: v = target_reg[0];
      ADDR_TARGET_GREEN: v = target_reg[1];
      ADDR_TARGET_BLUE: v = target_reg[2];
      ADDR_RESERVED_FIXED: v = fixed_reg;
      ADDR_AUTO_OFFSET: v = auto_reg;
      ADDR_TEST_D: v = test_d_reg;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // byte the read path shifts out next
  always_comb begin
    rd_byte = read_value(pointer_reg);
  end

  // pin synchronisers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      scl_meta_reg <= 1'b1;
      scl_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      coast_meta_reg <= 1'b0;
      coast_reg <= 1'b0;
    end else begin
      scl_meta_reg <= scl_in;
      scl_reg <= scl_meta_reg;
      scl_prev_reg <= scl_reg;
      sda_meta_reg <= sda_in;
      sda_reg <= sda_meta_reg;
      sda_prev_reg <= sda_reg;
      coast_meta_reg <= coast_pol_in;
      coast_reg <= coast_meta_reg;
    end
  end

  assign scl_rise = scl_reg && !scl_prev_reg;
  assign scl_fall = !scl_reg && scl_prev_reg;
  assign bus_start = scl_reg && scl_prev_reg && sda_prev_reg && !sda_reg;
  assign bus_stop = scl_reg && scl_prev_reg && !sda_prev_reg && sda_reg;

  // serial slave: sample on scl rise, drive on scl fall
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= BUS_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      pointer_reg <= 8'h00;
      rw_reg <= 1'b0;
      drive_reg <= 1'b0;
      wr_pulse_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
    end else begin
      wr_pulse_reg <= 1'b0;
      if (bus_start) begin
        state_reg <= BUS_ADDR;
        bit_cnt_reg <= 4'h0;
        drive_reg <= 1'b0;
      end else if (bus_stop) begin
        state_reg <= BUS_IDLE;
        drive_reg <= 1'b0;
      end else if (scl_rise) begin
        shift_reg <= {shift_reg[6:0], sda_reg};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end else if (scl_fall) begin
        unique case (state_reg)
          BUS_IDLE: drive_reg <= 1'b0;
          BUS_ADDR: begin
            if (bit_cnt_reg == BITS_PER_BYTE) begin
              if (shift_reg[7:1] == DEVICE_ADDR) begin
                rw_reg <= shift_reg[0];
                drive_reg <= 1'b1;
                state_reg <= BUS_ADDR_ACK;
              end else begin
                state_reg <= BUS_IDLE;
              end
            end
          end
          BUS_ADDR_ACK: begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              tx_reg <= rd_byte;
              drive_reg <= !rd_byte[7];
              state_reg <= BUS_READ;
            end else begin
              drive_reg <= 1'b0;
              state_reg <= BUS_SUB;
            end
          end
          BUS_SUB: begin
            if (bit_cnt_reg == BITS_PER_BYTE) begin
              pointer_reg <= shift_reg;
              drive_reg <= 1'b1;
              state_reg <= BUS_SUB_ACK;
            end
          end
          BUS_SUB_ACK: begin
            bit_cnt_reg <= 4'h0;
            drive_reg <= 1'b0;
            state_reg <= BUS_WRITE;
          end
          BUS_WRITE: begin
            if (bit_cnt_reg == BITS_PER_BYTE) begin
              wr_pulse_reg <= 1'b1;
              wr_addr_reg <= pointer_reg;
              wr_data_reg <= shift_reg;
              drive_reg <= 1'b1;
              state_reg <= BUS_WRITE_ACK;
            end
          end
          BUS_WRITE_ACK: begin
            pointer_reg <= pointer_reg + 8'h01;
            bit_cnt_reg <= 4'h0;
            drive_reg <= 1'b0;
            state_reg <= BUS_WRITE;
          end
          BUS_READ: begin
            if (bit_cnt_reg == BITS_PER_BYTE) begin
              // master acknowledges on the next rise; released meanwhile
              drive_reg <= 1'b0;
              pointer_reg <= pointer_reg + 8'h01;
              rw_reg <= 1'b0;
            end else if (bit_cnt_reg == BITS_PER_BYTE + 4'h1) begin
              bit_cnt_reg <= 4'h0;
              if (!shift_reg[0]) begin
                tx_reg <= rd_byte;
                drive_reg <= !rd_byte[7];
              end else begin
                state_reg <= BUS_IDLE;
              end
            end else begin
              drive_reg <= !tx_reg[6];
              tx_reg <= {tx_reg[6:0], 1'b0};
            end
          end
        endcase
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_n = !drive_reg;

  // line divider: upper byte held until low part is written
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      div_upper_reg <= RST_DIV_UPPER;  // see (R15)
      div_lower_reg <= RST_DIV_LOWER;
      div_active_reg <= RST_DIV_VALUE;
    end else if (wr_pulse_reg) begin
      if (wr_addr_reg == ADDR_DIV_UPPER) begin
        div_upper_reg <= wr_data_reg;  // see (R16)
      end
      if (wr_addr_reg == ADDR_DIV_LOWER) begin
        div_lower_reg <= wr_data_reg;
        // see (R13) (R14) (R19)
        div_active_reg <= clamp_div({div_upper_reg, wr_data_reg[DIV_LSB_HI:DIV_LSB_LO]});
      end
    end
  end

  assign line_divider_value = div_active_reg;
  assign divide_ratio = {1'b0, div_active_reg} + 13'h0001;  // see (R13) (R17)

  // format, test and fixed registers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      format_reg <= RST_OUT_FORMAT;
      test_a_reg <= RST_TEST_A;
      fixed_reg <= RST_RESERVED_FIXED;
      test_d_reg <= RST_TEST_D;
    end else if (wr_pulse_reg) begin
      if (wr_addr_reg == ADDR_OUT_FORMAT) begin
        format_reg <= wr_data_reg;  // see (R3)
      end
      if (wr_addr_reg == ADDR_TEST_A) begin
        test_a_reg <= wr_data_reg;  // see (R18)
      end
      if (wr_addr_reg == ADDR_RESERVED_FIXED) begin
        fixed_reg <= wr_data_reg;
      end
      if (wr_addr_reg == ADDR_TEST_D) begin
        test_d_reg <= wr_data_reg;
      end
    end
  end

  // auto offset control and target codes
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      auto_reg <= RST_AUTO_OFFSET;  // see (R7) (R8) (R10)
      for (int i = 0; i < 3; i++) begin
        target_reg[i] <= RST_TARGET;  // see (R5)
      end
    end else if (wr_pulse_reg) begin
      if (wr_addr_reg == ADDR_AUTO_OFFSET) begin
        auto_reg <= wr_data_reg;
      end
      if (wr_addr_reg == ADDR_TARGET_RED) begin
        target_reg[0] <= wr_data_reg;
      end
      if (wr_addr_reg == ADDR_TARGET_GREEN) begin
        target_reg[1] <= wr_data_reg;
      end
      if (wr_addr_reg == ADDR_TARGET_BLUE) begin
        target_reg[2] <= wr_data_reg;
      end
    end
  end

  assign out_format = out_format_s'(format_reg);
  assign auto_offset = auto_offset_s'(auto_reg);
  assign target_red = target_reg[0];
  assign target_green = target_reg[1];
  assign target_blue = target_reg[2];

  divider_hold_a: assert property ( // see (R16)
    @(posedge clock) disable iff (sys_rst)
    wr_pulse_reg && wr_addr_reg != ADDR_DIV_LOWER |=> $stable(line_divider_value))
    else $error("divider changed without a low-part write");

  divider_load_a: assert property ( // see (R19)
    @(posedge clock) disable iff (sys_rst)
    wr_pulse_reg && wr_addr_reg == ADDR_DIV_LOWER
      && {div_upper_reg, wr_data_reg[DIV_LSB_HI:DIV_LSB_LO]} >= DIV_VALUE_MIN
      && {div_upper_reg, wr_data_reg[DIV_LSB_HI:DIV_LSB_LO]} <= DIV_VALUE_MAX
    |=> line_divider_value == {$past(div_upper_reg), $past(wr_data_reg[7:4])})
    else $error("divider not loaded from upper byte and low nibble");

  divider_range_a: assert property ( // see (R14)
    @(posedge clock) disable iff (sys_rst)
    line_divider_value >= DIV_VALUE_MIN && line_divider_value <= DIV_VALUE_MAX)
    else $error("divider value out of range");

  ratio_sum_a: assert property ( // see (R13)
    @(posedge clock) disable iff (sys_rst)
    $changed(line_divider_value) |-> divide_ratio == {1'b0, line_divider_value} + 13'h0001)
    else $error("divide ratio is not value plus one");

  format_select_a: assert property ( // see (R3)
    @(posedge clock) disable iff (sys_rst)
    wr_pulse_reg && wr_addr_reg == ADDR_OUT_FORMAT
    |=> ##1 out_format.full_444 == $past(wr_data_reg[FMT_FULL_444_BIT], 2))
    else $error("output format select not taken");

  offset_enable_a: assert property ( // see (R7)
    @(posedge clock) disable iff (sys_rst)
    wr_pulse_reg && wr_addr_reg == ADDR_AUTO_OFFSET
    |=> auto_offset.enable == $past(wr_data_reg[7]) && auto_offset.hold == $past(wr_data_reg[6]))
    else $error("auto offset enable or hold not taken");

  update_mode_a: assert property ( // see (R10)
    @(posedge clock) disable iff (sys_rst)
    !(wr_pulse_reg && wr_addr_reg == ADDR_AUTO_OFFSET) |=> $stable(auto_offset.update_mode))
    else $error("update mode changed without a write");

  target_write_a: assert property ( // see (R5)
    @(posedge clock) disable iff (sys_rst)
    wr_pulse_reg && wr_addr_reg == ADDR_TARGET_GREEN |=> target_green == $past(wr_data_reg))
    else $error("green target not written");

  coast_status_a: assert property ( // see (R1)
    @(posedge clock) disable iff (sys_rst)
    ##2 coast_reg == $past(coast_pol_in, 2))
    else $error("coast polarity status wrong");

  test_readonly_a: assert property ( // see (R18)
    @(posedge clock) disable iff (sys_rst)
    read_value(ADDR_TEST_C) == RST_TEST_C && read_value(ADDR_REVISION) == REVISION)
    else $error("read-only register value wrong");

endmodule // capture_ctrl_register_bank

`default_nettype wire

/* File: tb/capture_ctrl_register_bank_tb.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_total++; $display("unexpected at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module capture_ctrl_register_bank_tb
  import capture_regs_pkg::*;
;
  localparam logic [6:0] DEV = 7'h4C; // arbitrary value
  localparam logic [7:0] REV = 8'hA3; // arbitrary value
  logic clock, sys_rst, coast_pol_in, scl_line, sda_low, sda_out, sda_oe_n, ok;
  logic [11:0] line_divider_value, prev;
  logic [12:0] divide_ratio;
  out_format_s out_format;
  auto_offset_s auto_offset;
  logic [7:0] target_red, target_green, target_blue, v;
  logic [15:0] w;
  int err_total = 0;
  int checks_done = 0;
  // open drain wire with pull-up
  wire logic sda_line = !sda_low && (sda_oe_n || sda_out);
  logic [7:0] ra [13] = '{8'h00, 8'h01, 8'h02, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A,
                          8'h1B, 8'h1C, 8'h1D, 8'h1E};
  logic [7:0] rv [13] = '{REV, 8'h69, 8'hD0, 8'hFF, 8'h00, 8'h00, 8'h04, 8'h04, 8'h04,
                          8'h04, 8'h11, 8'h26, 8'h00};
  logic [7:0] du [5] = '{8'h12, 8'h00, 8'hFF, 8'h00, 8'hFF};
  logic [7:0] dl [5] = '{8'h30, 8'h10, 8'hE0, 8'h00, 8'hF0};
  logic [11:0] de [5] = '{12'h123, 12'h001, 12'hFFE, 12'h001, 12'hFFE};

  capture_ctrl_register_bank #(.DEVICE_ADDR(DEV), .REVISION(REV)) u_capture_ctrl_register_bank (
    .clock(clock), .sys_rst(sys_rst), .scl_in(scl_line), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .coast_pol_in(coast_pol_in),
    .line_divider_value(line_divider_value), .divide_ratio(divide_ratio),
    .out_format(out_format), .auto_offset(auto_offset), .target_red(target_red),
    .target_green(target_green), .target_blue(target_blue));

  serial_host_model #(.PH(10)) u_serial_host_model (
    .clock(clock), .sda_line(sda_line), .scl_out(scl_line), .sda_low(sda_low));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic k;
    u_serial_host_model.write_reg(DEV, a, d, k);
    `CHK(k, 1'b1)
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic k;
    logic [7:0] q;
    u_serial_host_model.read_reg(DEV, a, q, k);
    `CHK(k, 1'b1)
    `CHK(q, exp)
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (99000) @(posedge clock);
    err_total++;
    results();
  end

  initial begin
    sys_rst = 1'b1;
    coast_pol_in = 1'b0;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (5) @(posedge clock);
    `CHK(line_divider_value, 12'h69D)
    `CHK(divide_ratio, 13'h069E)
    `CHK(auto_offset, 8'h26)
    `CHK(out_format, 8'hFF)
    `CHK({target_red, target_green, target_blue}, 24'h040404)
    for (int i = 0; i < 13; i++) begin
      rd(ra[i], rv[i]);
    end
    // per-channel targets
    wr(8'h19, 8'h5C);
    wr(8'h1A, 8'hA3);
    wr(8'h1B, 8'hFF);
    `CHK({target_red, target_green, target_blue}, 24'h5CA3FF)
    rd(8'h1A, 8'hA3);
    // two-byte transfers walk the pointer
    u_serial_host_model.write_pair(DEV, 8'h1A, 16'h3C7E, ok);
    `CHK({ok, target_green, target_blue}, 17'h13C7E)
    u_serial_host_model.read_pair(DEV, 8'h19, w, ok);
    `CHK({ok, w}, 17'h15C3C)
    // format select, fixed bits as required
    wr(8'h15, 8'hFC);
    `CHK(out_format.full_444, 1'b0)
    wr(8'h15, 8'hFE);
    `CHK(out_format, 8'hFE)
    rd(8'h15, 8'hFE);
    // every update mode with enable and hold toggled
    for (int m = 0; m < 4; m++) begin
      v = {m[0], m[1], 4'h9, m[1:0]};
      wr(8'h1D, v);
      `CHK(auto_offset, v)
      rd(8'h1D, v);
    end
    // divider: upper byte alone held, loads on low write
    prev = 12'h69D;
    for (int i = 0; i < 5; i++) begin
      wr(8'h01, du[i]);
      `CHK(line_divider_value, prev)
      wr(8'h02, dl[i]);
      repeat (2) @(posedge clock);
      `CHK(line_divider_value, de[i])
      `CHK(divide_ratio, {1'b0, de[i]} + 13'h0001)
      prev = de[i];
    end
    rd(8'h01, 8'hFF);
    // read-only places ignore writes, 16h keeps its write
    wr(8'h00, 8'hFF);
    rd(8'h00, REV);
    wr(8'h18, 8'hAA);
    rd(8'h18, 8'h04);
    wr(8'h17, 8'h55);
    rd(8'h17, 8'h00);
    wr(8'h16, 8'h3C);
    rd(8'h16, 8'h3C);
    wr(8'h1C, 8'h11);
    wr(8'h1E, 8'h00);
    rd(8'h40, 8'h00);
    // coast polarity readback
    coast_pol_in <= 1'b1;
    repeat (4) @(posedge clock);
    rd(8'h14, 8'h01);
    coast_pol_in <= 1'b0;
    repeat (4) @(posedge clock);
    rd(8'h14, 8'h00);
    // other device address is not answered
    u_serial_host_model.write_reg(DEV ^ 7'h01, 8'h19, 8'hEE, ok);
    `CHK(ok, 1'b0)
    rd(8'h19, 8'h5C);
    results();
  end
endmodule // capture_ctrl_register_bank_tb

`undef CHK
`default_nettype wire

/* File: tb/serial_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module serial_host_model #(
  parameter int PH = 10
) (
  // clock
  input wire logic clock,
  // bus wires
  input wire logic sda_line,
  output logic scl_out,
  output logic sda_low
);
  initial begin
    scl_out = 1'b1;
    sda_low = 1'b0;
  end

  task automatic half();
    repeat (PH) @(posedge clock);
  endtask

  // data moves only well inside the low phase
  task automatic bit_io(input logic b, output logic r);
    half();
    sda_low <= ~b;
    half();
    scl_out <= 1'b1;
    half();
    r = sda_line;
    scl_out <= 1'b0;
  endtask

  task automatic start();
    half();
    sda_low <= 1'b0;
    half();
    scl_out <= 1'b1;
    half();
    sda_low <= 1'b1;
    half();
    scl_out <= 1'b0;
  endtask

  task automatic stop();
    half();
    sda_low <= 1'b1;
    half();
    scl_out <= 1'b1;
    half();
    sda_low <= 1'b0;
    half();
  endtask

  // ninth bit released: ack from device, or nack from us on reads
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
                           output logic ok);
    logic [7:0] q;
    logic a0, a1, a2;
    start();
    byte_io({dev, 1'b0}, q, a0);
    byte_io(a, q, a1);
    byte_io(d, q, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask

  task automatic read_reg(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d,
                          output logic ok);
    logic [7:0] q;
    logic a0, a1, a2, a3;
    start();
    byte_io({dev, 1'b0}, q, a0);
    byte_io(a, q, a1);
    start();
    byte_io({dev, 1'b1}, q, a2);
    byte_io(8'hFF, d, a3);
    stop();
    ok = a0 & a1 & a2;
  endtask

  // two data bytes in one write: the pointer steps between them
  task automatic write_pair(input logic [6:0] dev, input logic [7:0] a, input logic [15:0] d,
                            output logic ok);
    logic [7:0] q;
    logic a0, a1, a2, a3;
    start();
    byte_io({dev, 1'b0}, q, a0);
    byte_io(a, q, a1);
    byte_io(d[15:8], q, a2);
    byte_io(d[7:0], q, a3);
    stop();
    ok = a0 & a1 & a2 & a3;
  endtask

  // two bytes in one read: we ack the first and refuse the second
  task automatic read_pair(input logic [6:0] dev, input logic [7:0] a, output logic [15:0] d,
                           output logic ok);
    logic [7:0] q;
    logic a0, a1, a2, r;
    start();
    byte_io({dev, 1'b0}, q, a0);
    byte_io(a, q, a1);
    start();
    byte_io({dev, 1'b1}, q, a2);
    for (int i = 15; i >= 8; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(1'b0, r);
    byte_io(8'hFF, q, r);
    d[7:0] = q;
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule // serial_host_model

`default_nettype wire
